// >>> design/pahwm_pkg.sv
// Constants and types for the packed and wide multiply datapath
package pahwm_pkg;
    localparam int unsigned WORD_W     = 32;
    localparam int unsigned HALF_W     = 16;
    localparam int unsigned PAIR_W     = 64;
    localparam int unsigned WIDE_W     = 48;
    localparam int unsigned OP_W       = 5;
    localparam int unsigned REG_W      = 5;
    localparam int unsigned INSN_W     = 32;
    localparam int unsigned OP_LSB     = 6;
    localparam int unsigned DST_LSB    = 23;
    localparam int unsigned STAGES     = 4;
    localparam logic [OP_W-1:0] OP_DUAL_HALFWORD = 5'h00;
    localparam logic [OP_W-1:0] OP_HIGH_BY_WORD  = 5'h14;
    localparam logic [WORD_W-1:0] WORD_ZERO      = 32'h0000_0000;
    localparam logic [REG_W-1:0]  REG_ZERO       = 5'h00;

    typedef enum logic [1:0] {
        PAHWM_OP_NONE = 2'b00,
        PAHWM_OP_DUAL = 2'b01,
        PAHWM_OP_HIWD = 2'b11
    } pahwm_op_t;
endpackage

// >>> design/pahwm_mul_if.sv
// Operand and result bundle between issue stage and multiply array
`timescale 1ns/10ps
interface pahwm_mul_if;
    logic [pahwm_pkg::WORD_W-1:0] first_source_operand;
    logic [pahwm_pkg::WORD_W-1:0] second_source_operand;
    pahwm_pkg::pahwm_op_t         op;
    logic [pahwm_pkg::PAIR_W-1:0] result;
    modport issuer (output first_source_operand, output second_source_operand, output op,
                    input result);
    modport array (input first_source_operand, input second_source_operand, input op,
                   output result);
endinterface

// >>> design/pahwm_mul_array.sv
// Combinational multiply array for both operations
`timescale 1ns/10ps
module pahwm_mul_array (
    pahwm_mul_if.array mi
);
    localparam int unsigned W = pahwm_pkg::WORD_W;
    localparam int unsigned H = pahwm_pkg::HALF_W;

    // Packed signed halfword products
    wire signed [H-1:0]   lo_a = mi.first_source_operand[H-1:0];
    wire signed [H-1:0]   lo_b = mi.second_source_operand[H-1:0];
    wire signed [H-1:0]   hi_a = mi.first_source_operand[W-1:H];
    wire signed [H-1:0]   hi_b = mi.second_source_operand[W-1:H];
    wire signed [W-1:0]   lo_prod = lo_a * lo_b; // (RULE1)
    wire signed [W-1:0]   hi_prod = hi_a * hi_b; // (RULE1)
    wire [pahwm_pkg::PAIR_W-1:0] dual_res = {hi_prod, lo_prod}; // (RULE2)

    // Signed high halfword times signed word
    wire signed [W-1:0]   word_b = mi.second_source_operand; // (RULE7)
    wire signed [pahwm_pkg::WIDE_W-1:0] wide_prod = hi_a * word_b; // (RULE5) (RULE6)
    wire [pahwm_pkg::PAIR_W-1:0] wide_res =
        {{(pahwm_pkg::PAIR_W-pahwm_pkg::WIDE_W){wide_prod[pahwm_pkg::WIDE_W-1]}},
         wide_prod}; // (RULE8) (RULE9)

    assign mi.result = (mi.op == pahwm_pkg::PAHWM_OP_HIWD) ? wide_res : dual_res;
endmodule

// >>> design/pahwm_top.sv
// Four-cycle multiplier-unit datapath for dual halfword and high-by-word multiply
// Function
// (RULE1) Two signed halfword products from packed operands
// (RULE2) Full 32-bit products into 64-bit pair
// (RULE3) Lower halfword product goes to even register
// (RULE4) Upper halfword product goes to odd register
// (RULE5) Single 16 by 32 multiply, one product
// (RULE6) Upper half of first operand, signed
// (RULE7) Whole second operand as signed word
// (RULE8) 48-bit product in low pair bits
// (RULE9) Sign extend from bit 47 to 64
// (RULE10) Read in E1, write in E4; false condition is no-op
// (RULE11) Opfield 00000 dual, 10100 high-by-word, bits 10:6
`timescale 1ns/10ps
module pahwm_top (
    // Clock and reset
    input  wire logic                          CLK,
    input  wire logic                          SRST,
    // Issue
    input  wire logic                          ISSUE_VALID,
    input  wire logic                          COND_TRUE,
    input  wire logic [pahwm_pkg::INSN_W-1:0]  INSN,
    input  wire logic [pahwm_pkg::WORD_W-1:0]  FIRST_SOURCE_OPERAND,
    input  wire logic [pahwm_pkg::WORD_W-1:0]  SECOND_SOURCE_OPERAND,
    // Unit occupancy and decode
    output logic                               UNIT_BUSY,
    output logic                               OP_ACCEPTED,
    // Register file write-back
    output logic                               WB_VALID,
    output logic [pahwm_pkg::REG_W-1:0]        WB_EVEN_ADDR,
    output logic [pahwm_pkg::REG_W-1:0]        WB_ODD_ADDR,
    output logic [pahwm_pkg::WORD_W-1:0]       WB_EVEN_DATA,
    output logic [pahwm_pkg::WORD_W-1:0]       WB_ODD_DATA
);
    localparam int unsigned S = pahwm_pkg::STAGES;
    localparam int unsigned W = pahwm_pkg::WORD_W;
    localparam int unsigned P = pahwm_pkg::PAIR_W;
    localparam int unsigned R = pahwm_pkg::REG_W;
    localparam int unsigned I = pahwm_pkg::INSN_W;
    // One delay-line entry per stage after E1: E2, E3, E4
    localparam int unsigned D = S - 1;
    // Word select within a register pair
    localparam logic        EVEN_WORD = 1'h0;
    localparam logic        ODD_WORD  = 1'h1;

    // Opfield of a multiplier-unit instruction word
    function automatic logic [pahwm_pkg::OP_W-1:0] opfield_of(
        input logic [I-1:0] insn
    );
        opfield_of = insn[pahwm_pkg::OP_LSB +: pahwm_pkg::OP_W];
    endfunction

    // Even register of the destination pair; low field bit ignored
    function automatic logic [R-1:0] pair_even_of(
        input logic [I-1:0] insn
    );
        pair_even_of = {insn[pahwm_pkg::DST_LSB+1 +: R-1], EVEN_WORD};
    endfunction

    // Odd partner of an even register
    function automatic logic [R-1:0] pair_odd_of(
        input logic [R-1:0] even
    );
        pair_odd_of = {even[R-1:1], ODD_WORD};
    endfunction

    // One word of a register-pair value
    function automatic logic [W-1:0] pair_word(
        input logic [P-1:0] pair,
        input logic         odd
    );
        pair_word = odd ? pair[P-1:W] : pair[W-1:0];
    endfunction

    // Operation named by the opfield; any other code is not for this unit
    function automatic pahwm_pkg::pahwm_op_t decode_op(
        input logic [I-1:0] insn
    );
        logic [pahwm_pkg::OP_W-1:0] f;
        f = opfield_of(insn);
        if (f == pahwm_pkg::OP_DUAL_HALFWORD) begin
            decode_op = pahwm_pkg::PAHWM_OP_DUAL;
        end else if (f == pahwm_pkg::OP_HIGH_BY_WORD) begin
            decode_op = pahwm_pkg::PAHWM_OP_HIWD;
        end else begin
            decode_op = pahwm_pkg::PAHWM_OP_NONE;
        end
    endfunction

    // Decode: unknown opfield or false condition issues nothing
    wire pahwm_pkg::pahwm_op_t dec_op   = decode_op(INSN); // (RULE11)
    wire                       op_known = (dec_op != pahwm_pkg::PAHWM_OP_NONE); // (RULE11)
    wire                       issue_ok = ISSUE_VALID && COND_TRUE && op_known; // (RULE10)
    wire [R-1:0]               dst_even = pair_even_of(INSN);

    // Multiply array works on the operands held through E2
    pahwm_mul_if mi ();

    // E1 operand capture
    logic [W-1:0]         a_q;
    logic [W-1:0]         b_q;
    pahwm_pkg::pahwm_op_t op_q;
    logic [W-1:0]         a_d;
    logic [W-1:0]         b_d;
    pahwm_pkg::pahwm_op_t op_d;

    // Stage valids and destinations; entry 0 is E2, entry D-1 is E4
    logic [D-1:0]         vld_q;
    logic [D-1:0]         vld_d;
    logic [D-1:0][R-1:0]  dst_q;
    wire  [D-1:0][R-1:0]  dst_d;

    // Array result held in E3, write-back words held from E4 on
    logic [P-1:0]         prod_q;
    logic [P-1:0]         prod_d;
    logic [W-1:0]         wb_even_q;
    logic [W-1:0]         wb_even_d;
    logic [W-1:0]         wb_odd_q;
    logic [W-1:0]         wb_odd_d;
    wire                  prod_load = vld_q[0];
    wire                  wb_load   = vld_q[D-2];

    // Operands only move on an accepted issue
    assign a_d  = issue_ok ? FIRST_SOURCE_OPERAND : a_q; // (RULE10)
    assign b_d  = issue_ok ? SECOND_SOURCE_OPERAND : b_q; // (RULE10)
    assign op_d = issue_ok ? dec_op : op_q;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            a_q <= pahwm_pkg::WORD_ZERO;
            b_q <= pahwm_pkg::WORD_ZERO;
        end else begin
            a_q <= a_d;
            b_q <= b_d;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            op_q <= pahwm_pkg::PAHWM_OP_NONE;
        end else begin
            op_q <= op_d;
        end
    end

    assign mi.first_source_operand  = a_q;
    assign mi.second_source_operand = b_q;
    assign mi.op                    = op_q;

    pahwm_mul_array u_array (
        .mi (mi)
    );

    // Valid shifts every cycle, so issue may follow issue back to back
    assign vld_d = {vld_q[D-2:0], issue_ok}; // (RULE10)

    always_ff @(posedge CLK) begin
        if (SRST) begin
            vld_q <= '0;
        end else begin
            vld_q <= vld_d;
        end
    end

    // Destination follows its valid down the stages
    genvar g;
    generate
        for (g = 0; g < D; g++) begin : g_dst
            if (g == 0) begin : g_head
                assign dst_d[g] = issue_ok ? dst_even : dst_q[g];
            end else begin : g_tail
                assign dst_d[g] = dst_q[g-1];
            end
        end
    endgenerate

    always_ff @(posedge CLK) begin
        if (SRST) begin
            dst_q <= '0;
        end else begin
            dst_q <= dst_d;
        end
    end

    // Array output is only captured behind a live E2 entry
    assign prod_d = prod_load ? mi.result : prod_q;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            prod_q <= '0;
        end else begin
            prod_q <= prod_d;
        end
    end

    // Write-back words keep the last result while no write-back is due
    assign wb_even_d = wb_load ? pair_word(prod_q, EVEN_WORD) : wb_even_q; // (RULE3)
    assign wb_odd_d  = wb_load ? pair_word(prod_q, ODD_WORD) : wb_odd_q; // (RULE4)

    always_ff @(posedge CLK) begin
        if (SRST) begin
            wb_even_q <= pahwm_pkg::WORD_ZERO;
        end else begin
            wb_even_q <= wb_even_d;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            wb_odd_q <= pahwm_pkg::WORD_ZERO;
        end else begin
            wb_odd_q <= wb_odd_d;
        end
    end

    // Write-back lands at the end of E4; occupancy covers E2 and E3
    assign OP_ACCEPTED  = issue_ok;
    assign UNIT_BUSY    = |vld_q[D-2:0]; // (RULE10)
    assign WB_VALID     = vld_q[D-1]; // (RULE10)
    assign WB_EVEN_ADDR = dst_q[D-1];
    assign WB_ODD_ADDR  = pair_odd_of(dst_q[D-1]);
    assign WB_EVEN_DATA = wb_even_q;
    assign WB_ODD_DATA  = wb_odd_q;
endmodule

// >>> dv/pahwm_regfile_model.sv
// Register file model taking pair write-backs
`timescale 1ns/10ps
module pahwm_regfile_model (
    // Write-back
    input wire logic        clk,
    input wire logic        we,
    input wire logic [4:0]  ea,
    input wire logic [4:0]  oa,
    input wire logic [31:0] ed,
    input wire logic [31:0] od
);
    logic [31:0] rf [32] = '{default: 32'h0};
    always @(posedge clk) if (we === 1'b1) begin
        rf[ea] <= ed;
        rf[oa] <= od;
    end
endmodule

// >>> dv/pahwm_top_assertions.sv
// Port checks for the multiply datapath
`timescale 1ns/10ps
module pahwm_top_assertions (
    input wire logic        CLK,
    input wire logic        SRST,
    input wire logic        ISSUE_VALID,
    input wire logic        COND_TRUE,
    input wire logic [31:0] INSN,
    input wire logic [31:0] FIRST_SOURCE_OPERAND,
    input wire logic [31:0] SECOND_SOURCE_OPERAND,
    input wire logic        UNIT_BUSY,
    input wire logic        OP_ACCEPTED,
    input wire logic        WB_VALID,
    input wire logic [4:0]  WB_EVEN_ADDR,
    input wire logic [4:0]  WB_ODD_ADDR,
    input wire logic [31:0] WB_EVEN_DATA,
    input wire logic [31:0] WB_ODD_DATA
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    wire [4:0]  op = INSN[10:6];
    wire [31:0] a = FIRST_SOURCE_OPERAND;
    wire [31:0] b = SECOND_SOURCE_OPERAND;
    wire [31:0] lo = $signed(a[15:0]) * $signed(b[15:0]);
    wire [31:0] hi = $signed(a[31:16]) * $signed(b[31:16]);
    wire [63:0] hw = $signed(a[31:16]) * $signed(b);
    a_decode_ok: assert property (OP_ACCEPTED == (ISSUE_VALID && COND_TRUE &&
        (op == 5'h00 || op == 5'h14))) else $error("decode mismatch");
    a_wb_latency: assert property (OP_ACCEPTED |-> ##3 WB_VALID)
        else $error("late write-back");
    a_wb_cause: assert property (WB_VALID |-> $past(OP_ACCEPTED, 3))
        else $error("write-back without op");
    a_unit_busy: assert property (OP_ACCEPTED |=> UNIT_BUSY [*2])
        else $error("unit not busy");
    a_busy_cause: assert property (UNIT_BUSY |->
        $past(OP_ACCEPTED) || $past(OP_ACCEPTED, 2)) else $error("busy without op");
    a_pair_addr: assert property (WB_VALID |-> WB_ODD_ADDR == (WB_EVEN_ADDR | 5'h01)
        && WB_EVEN_ADDR == {$past(INSN[27:24], 3), 1'b0}) else $error("pair address");
    a_dual_even: assert property (WB_VALID && $past(op, 3) == 5'h00 |->
        WB_EVEN_DATA == $past(lo, 3)) else $error("low product");
    a_dual_odd: assert property (WB_VALID && $past(op, 3) == 5'h00 |->
        WB_ODD_DATA == $past(hi, 3)) else $error("high product");
    a_wide_low: assert property (WB_VALID && $past(op, 3) == 5'h14 |->
        {WB_ODD_DATA[15:0], WB_EVEN_DATA} == $past(hw[47:0], 3)) else $error("wide product");
    a_wide_sext: assert property (WB_VALID && $past(op, 3) == 5'h14 |->
        WB_ODD_DATA[31:16] == {16{$past(hw[47], 3)}}) else $error("sign extension");
    c_dual: cover property (OP_ACCEPTED && op == 5'h00);
    c_wide: cover property (OP_ACCEPTED && op == 5'h14);
    c_false: cover property (ISSUE_VALID && !COND_TRUE);
endmodule
bind pahwm_top pahwm_top_assertions chk (.*);

// >>> dv/packed_and_wide_multiply_ops_tb.sv
// Self-checking bench for the multiply datapath
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s exp %h got %h", n, e, g); end end
module packed_and_wide_multiply_ops_tb;
    logic        clk = 1'b0, srst = 1'b1, iv = 1'b0, ct = 1'b0;
    logic [31:0] insn = 32'h0, fa = 32'h0, fb = 32'h0;
    wire         wv;
    wire  [4:0]  ea, oa;
    wire  [31:0] ed, od;
    int          fail_count = 0, samples_checked = 0, wb_n = 0;
    pahwm_top dut (.CLK(clk), .SRST(srst), .ISSUE_VALID(iv), .COND_TRUE(ct), .INSN(insn),
        .FIRST_SOURCE_OPERAND(fa), .SECOND_SOURCE_OPERAND(fb), .UNIT_BUSY(), .OP_ACCEPTED(),
        .WB_VALID(wv), .WB_EVEN_ADDR(ea), .WB_ODD_ADDR(oa), .WB_EVEN_DATA(ed), .WB_ODD_DATA(od));
    pahwm_regfile_model m (.clk(clk), .we(wv), .ea(ea), .oa(oa), .ed(ed), .od(od));
    initial forever #50 clk = ~clk;
    always @(posedge clk) if (wv === 1'b1) wb_n++;
    function automatic [63:0] dual(input [31:0] a, b);
        logic signed [31:0] l, h;
        l = $signed(a[15:0]) * $signed(b[15:0]);
        h = $signed(a[31:16]) * $signed(b[31:16]);
        return {h, l};
    endfunction
    function automatic [63:0] wide(input [31:0] a, b);
        logic signed [63:0] w;
        w = $signed(a[31:16]) * $signed(b);
        return w;
    endfunction
    task automatic put(input [4:0] op, d, input [31:0] a, b, input c);
        @(posedge clk);
        iv <= 1'b1;
        ct <= c;
        insn <= {4'h0, d, 12'h0, op, 6'h0};
        fa <= a;
        fb <= b;
    endtask
    task automatic idle();
        @(posedge clk);
        iv <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
    task automatic t_dual();
        put(5'h00, 5'h09, 32'h6a32_1193, 32'hb174_6ca4, 1'b1);
        idle();
        `CHK("dual", dual(32'h6a32_1193, 32'hb174_6ca4), {m.rf[9], m.rf[8]})
    endtask
    task automatic t_wide();
        put(5'h14, 5'h08, 32'h6a32_1193, 32'hb174_6ca4, 1'b1);
        idle();
        `CHK("wide", wide(32'h6a32_1193, 32'hb174_6ca4), {m.rf[9], m.rf[8]})
    endtask
    task automatic t_b2b();
        put(5'h00, 5'h02, 32'h8000_7fff, 32'h8000_8000, 1'b1);
        put(5'h14, 5'h04, 32'h8000_0000, 32'h7fff_ffff, 1'b1);
        idle();
        `CHK("dual b2b", dual(32'h8000_7fff, 32'h8000_8000), {m.rf[3], m.rf[2]})
        `CHK("wide b2b", wide(32'h8000_0000, 32'h7fff_ffff), {m.rf[5], m.rf[4]})
    endtask
    task automatic t_refuse();
        put(5'h00, 5'h06, 32'h1234_5678, 32'h1111_2222, 1'b0);
        put(5'h01, 5'h06, 32'h1234_5678, 32'h1111_2222, 1'b1);
        idle();
        `CHK("writes", 4, wb_n)
        `CHK("refused", 32'h0, m.rf[6])
    endtask
    task automatic test_done();
        if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        t_dual();
        t_wide();
        t_b2b();
        t_refuse();
        test_done();
    end
    initial begin
        #100000;
        fail_count++;
        test_done();
    end
endmodule
